// File: core/efcs_bank_map.sv
// Purpose: Decodes byte addresses into flash bank numbers
// Assumes: Segment select is stable while addresses are decoded
// Notes:   One decoder per address, all combinational

`timescale 1ns/1ps

module efcs_bank_map
   import efcs_pkg::*;
#(
   parameter int N = 4
)
(
   input wire logic [N-1:0][23:0] addr_i,
   input wire logic seg1_i,
   output logic [N-1:0] hit_o,
   output logic [N-1:0][1:0] bank_o
);

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_dec
         wire [23:0] a = addr_i[g];
         wire lo_0 = !seg1_i && a < B0_S0_END;
         wire lo_1 = !seg1_i && a >= B0_S0_END && a < B1_S0_END;
         wire s1_0 = seg1_i && a >= S1_BEG && a < B0_S1_END;
         wire s1_1 = seg1_i && a >= B0_S1_END && a < B2_BEG;
         // Split window of the second bank in the low mapping
         wire hi_1 = !seg1_i && a >= B1_HI_BEG && a < B2_BEG;
         wire b2 = a >= B2_BEG && a < B3_BEG;
         wire b3 = a >= B3_BEG && a < FLASH_END;
         wire is0 = lo_0 || s1_0;
         wire is1 = lo_1 || s1_1 || hi_1;
         assign hit_o[g] = is0 || is1 || b2 || b3;
         assign bank_o[g] = {b2 || b3, is1 || b3};
      end
   endgenerate

endmodule

// File: core/efcs_pkg.sv
// Purpose: Shared constants and types of the flash command sequencer
// Assumes: 16-bit register port, 24-bit flash byte addresses
// Notes:   Times are in nanoseconds, accumulated from the period register

package efcs_pkg;

   // ---------------------------------------------------------------
   // Register offsets and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_ARG1 = 4'h1;
   localparam logic [3:0] REG_ARG2 = 4'h2;
   localparam logic [3:0] REG_ARG3 = 4'h3;
   localparam logic [3:0] REG_PERIOD = 4'h4;
   localparam logic [3:0] REG_STACK = 4'h5;
   localparam logic [3:0] REG_CTRL = 4'h6;
   localparam logic [3:0] REG_STAT = 4'h7;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam int CTRL_SEG_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_PROT_BIT = 1;
   localparam logic PROT_RESET = 1'b0;
   localparam logic SEG_RESET = 1'b0;

   // ---------------------------------------------------------------
   // Commands, keys and status codes
   // ---------------------------------------------------------------
   localparam logic [11:0] CMD_SINGLE = 12'h55A;
   localparam logic [11:0] CMD_DOUBLE = 12'hDD4;
   localparam logic [11:0] CMD_BLOCK = 12'hAA5;
   localparam logic [15:0] CMD_ERASE = 16'hEEEE;
   localparam logic [15:0] CMD_PROTECT = 16'hCCCC;
   localparam logic [15:0] CMD_STATUS = 16'h7777;
   localparam logic [15:0] KEY_A = 16'h5555;
   localparam logic [15:0] KEY_B = 16'h3333;
   localparam logic [15:0] KEY_C = 16'hAAAA;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_PROG = 8'h03;
   localparam logic [7:0] ERR_ADDR = 8'h04;
   localparam logic [7:0] ERR_PERIOD = 8'h05;
   localparam logic [7:0] ERR_STACK = 8'h06;
   localparam logic [7:0] ERR_BANK = 8'h07;
   localparam logic [7:0] ERR_ERASE = 8'h08;
   localparam logic [7:0] ERR_SOURCE = 8'h09;
   localparam logic [7:0] ERR_COUNT = 8'h0A;
   localparam logic [7:0] ERR_BAD_CMD = 8'hFF;

   // ---------------------------------------------------------------
   // Limits and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] STACK_MIN_WORDS = 16'h0032;
   localparam logic [15:0] PERIOD_MIN_NS = 16'h001E;
   localparam logic [15:0] PERIOD_MAX_NS = 16'h01F4;
   localparam logic [16:0] PAGE_SPAN = 17'h0_4000;
   localparam logic [3:0] SEG_LAST = 4'h4;
   localparam logic [15:0] BANK_LAST = 16'h0003;
   localparam logic [3:0] RETRY_LIMIT = 4'hA;
   localparam logic [31:0] PROG_PULSE_NS = 32'h0000_9C40;
   localparam logic [31:0] ERASE_PULSE_NS = 32'hB2D0_5E00;

   // ---------------------------------------------------------------
   // Bank map bounds
   // ---------------------------------------------------------------
   localparam logic [23:0] B0_S0_END = 24'h00_4000;
   localparam logic [23:0] B1_S0_END = 24'h00_8000;
   localparam logic [23:0] B1_HI_BEG = 24'h01_8000;
   localparam logic [23:0] S1_BEG = 24'h01_0000;
   localparam logic [23:0] B0_S1_END = 24'h01_4000;
   localparam logic [23:0] B2_BEG = 24'h02_0000;
   localparam logic [23:0] B3_BEG = 24'h03_8000;
   localparam logic [23:0] FLASH_END = 24'h05_0000;

   typedef enum logic [7:0] {
      S_IDLE = 8'h01,
      S_ARMED = 8'h02,
      S_CHECK = 8'h04,
      S_FETCH = 8'h08,
      S_LOAD = 8'h10,
      S_PULSE = 8'h20,
      S_VERIFY = 8'h40,
      S_FINISH = 8'h80
   } efcs_state_e;

endpackage

// File: core/efcs_sequencer.sv
// Purpose: Command front end of the on-chip flash: unlock, check, run, report
// Assumes: Register port on clock_i; array and source port on the same clock
// Notes:   Pulse time is accumulated from the period word, so it tracks the CPU clock
//
// How it works
// (RQ1) Array word is 32 bits so a double word moves in one cycle
// (RQ2) Four banks of 16K, 48K, 96K, 96K bytes, each erased alone
// (RQ3) Low banks map to segment 0 or segment 1 at start-up
// (RQ4) Low mapping gives bank 1 two windows, high mapping one range
// (RQ5) With protection on, data reads not fetched from flash are blocked
// (RQ6) Software loads registers 0 to 4, unlocks, then reads register 0
// (RQ7) Unlock is a direct write then indirect write via R6..R15, same address
// (RQ8) Completion leaves the status code in register 0
// (RQ9) Parameters checked first; program or erase verified and retried
// (RQ10) At least 50 free stack words needed before program or erase
// (RQ11) Command 55As: offset, data word, unused, period
// (RQ12) Command DD4s: offset, low word, high word, period
// (RQ13) Command AA5s: first offset, last offset, source, period
// (RQ14) Command EEEE: key 5555, bank twice, period
// (RQ15) Command CCCC: keys 5555, 3333, AAAA, period; sets protection
// (RQ16) Command 7777 reads status; only the period is used
// (RQ17) Target offsets for word and double word must be even
// (RQ18) Block span from first to last offset is 0 up to below 16384
// (RQ19) Source address plus span stays below 16384, paged by CPU
// (RQ20) Erase refused when the two bank numbers differ
// (RQ21) Register 4 holds the clock period in ns for timing
// (RQ22) CPU clock must stay between 5 and 32 MHz during operations; code accepts periods of 30 to 500 ns
// (RQ23) Status 00h good, 04h bad address, FFh bad command
// (RQ24) Only two back-to-back unlock writes start an operation

`timescale 1ns/1ps

module efcs_sequencer
   import efcs_pkg::*;
#(
   parameter logic [31:0] PROG_NS = PROG_PULSE_NS,
   parameter logic [31:0] ERASE_NS = ERASE_PULSE_NS,
   // Revision word returned by the status command; value is arbitrary
   parameter logic [15:0] REVISION = 16'h0100
)
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [15:0] reg_rdata_o,
   input wire logic trig_we_i,
   input wire logic [23:0] trig_addr_i,
   input wire logic trig_indirect_i,
   input wire logic [3:0] trig_gpr_i,
   input wire logic data_rd_i,
   input wire logic [23:0] data_rd_addr_i,
   input wire logic fetch_from_flash_i,
   output logic read_block_o,
   output logic array_prog_o,
   output logic array_erase_o,
   output logic [23:0] array_addr_o,
   output logic [1:0] array_bank_o,
   output logic [31:0] array_wdata_o,
   output logic [1:0] array_wmask_o,
   input wire logic array_ok_i,
   output logic src_rd_o,
   output logic [15:0] src_addr_o,
   input wire logic [15:0] src_data_i,
   output logic busy_o,
   output logic user_protection_bit_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   efcs_state_e state;
   efcs_state_e next_state;
   logic [15:0] gpr [0:4];
   logic [15:0] stack_free;
   logic flash_segment_select;
   logic [7:0] err;
   logic [7:0] next_err;
   logic [15:0] cur_off;
   logic [15:0] next_off;
   logic [31:0] acc_ns;
   logic [31:0] next_acc;
   logic [3:0] retry;
   logic [3:0] next_retry;
   logic [23:0] armed_addr;
   logic [31:0] wdata;
   logic [31:0] next_wdata;

   // ---------------------------------------------------------------
   // Command decode and parameter checks
   // ---------------------------------------------------------------
   wire [15:0] cmd = gpr[0];
   wire is_single = cmd[15:4] == CMD_SINGLE; // RQ11
   wire is_double = cmd[15:4] == CMD_DOUBLE; // RQ12
   wire is_block = cmd[15:4] == CMD_BLOCK; // RQ13
   wire is_erase = cmd == CMD_ERASE; // RQ14
   wire is_prot = cmd == CMD_PROTECT; // RQ15
   wire is_stat = cmd == CMD_STATUS; // RQ16
   wire is_prog = is_single || is_double || is_block;
   wire is_known = is_prog || is_erase || is_prot || is_stat;
   wire [3:0] seg = cmd[3:0];
   wire [23:0] first_addr = {4'h0, seg, gpr[1]};
   wire [23:0] last_addr = {4'h0, seg, gpr[2]};
   wire [16:0] span = {1'b0, gpr[2]} - {1'b0, gpr[1]};
   wire [16:0] src_end = {1'b0, gpr[3]} + span;
   wire [3:0] map_hit;
   wire [3:0][1:0] map_bank;
   wire period_ok = gpr[4] >= PERIOD_MIN_NS && gpr[4] <= PERIOD_MAX_NS; // RQ21 RQ22
   wire stack_ok = stack_free >= STACK_MIN_WORDS; // RQ10
   wire addr_ok = map_hit[1] && !gpr[1][0] && seg <= SEG_LAST; // RQ17
   wire last_ok = map_hit[3] && !gpr[2][0];
   wire span_bad = span >= PAGE_SPAN || !last_ok; // RQ18
   wire src_bad = src_end >= PAGE_SPAN; // RQ19
   wire bank_bad = gpr[2] != gpr[3] || gpr[2] > BANK_LAST; // RQ20
   wire keys_bad = gpr[1] != KEY_A || gpr[2] != KEY_B || gpr[3] != KEY_C;
   wire [7:0] check_err; // RQ9 RQ23
   assign check_err =
      !is_known ? ERR_BAD_CMD :
      !period_ok ? ERR_PERIOD :
      ((is_prog || is_erase || is_prot) && !stack_ok) ? ERR_STACK :
      (is_erase && gpr[1] != KEY_A) ? ERR_BAD_CMD :
      (is_erase && bank_bad) ? ERR_BANK :
      (is_prot && keys_bad) ? ERR_BAD_CMD :
      (is_prog && !addr_ok) ? ERR_ADDR :
      (is_block && span_bad) ? ERR_COUNT :
      (is_block && src_bad) ? ERR_SOURCE :
      ERR_NONE;

   // Second half of the unlock pair must name a spare register
   wire spare_gpr = trig_gpr_i >= 4'h6;
   wire unlock_first = trig_we_i && !trig_indirect_i && !trig_addr_i[0] && map_hit[0];
   wire unlock_second = trig_we_i && trig_indirect_i && spare_gpr &&
      trig_addr_i == armed_addr;
   wire [31:0] acc_sum = acc_ns + {16'h0000, gpr[4]};
   wire [31:0] pulse_ns = is_erase ? ERASE_NS : PROG_NS;
   wire idle_like = next_state == S_IDLE || next_state == S_ARMED;
   wire sw_write = reg_we_i && (state == S_IDLE || state == S_ARMED);

   // ---------------------------------------------------------------
   // Bank decoders
   // ---------------------------------------------------------------
   efcs_bank_map #(
      .N(4)
   ) u_map (
      .addr_i({last_addr, data_rd_addr_i, first_addr, trig_addr_i}),
      .seg1_i(flash_segment_select), // RQ3 RQ4
      .hit_o(map_hit),
      .bank_o(map_bank)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_err = err;
      next_off = cur_off;
      next_acc = acc_ns;
      next_retry = retry;
      next_wdata = wdata;
      case (state)
         S_IDLE:
         begin
            if (unlock_first)
            begin
               next_state = S_ARMED; // RQ7
            end
         end
         S_ARMED:
         begin
            // Any register or flash write other than the second half disarms
            if (sw_write)
            begin
               next_state = S_IDLE; // RQ24
            end
            else if (trig_we_i)
            begin
               next_state = unlock_second ? S_CHECK : S_IDLE; // RQ7 RQ24
            end
         end
         S_CHECK:
         begin
            next_err = check_err; // RQ9
            next_off = gpr[1];
            next_acc = 32'h0000_0000;
            next_retry = 4'h0;
            next_wdata = {is_double ? gpr[3] : 16'h0000, gpr[2]}; // RQ1 RQ12
            if (check_err != ERR_NONE || is_prot || is_stat)
            begin
               next_state = S_FINISH;
            end
            else
            begin
               next_state = is_block ? S_FETCH : S_PULSE;
            end
         end
         S_FETCH:
         begin
            next_state = S_LOAD;
         end
         S_LOAD:
         begin
            next_wdata = {16'h0000, src_data_i}; // RQ13
            next_state = S_PULSE;
         end
         S_PULSE:
         begin
            next_acc = acc_sum; // RQ21
            if (acc_sum >= pulse_ns)
            begin
               next_state = S_VERIFY;
            end
         end
         S_VERIFY:
         begin
            next_acc = 32'h0000_0000;
            if (array_ok_i)
            begin
               if (is_block && cur_off != gpr[2])
               begin
                  next_off = cur_off + 16'h0002;
                  next_retry = 4'h0;
                  next_state = S_FETCH;
               end
               else
               begin
                  next_state = S_FINISH;
               end
            end
            else if (retry == RETRY_LIMIT)
            begin
               next_err = is_erase ? ERR_ERASE : ERR_PROG; // RQ9
               next_state = S_FINISH;
            end
            else
            begin
               next_retry = retry + 4'h1; // RQ9
               next_state = S_PULSE;
            end
         end
         S_FINISH:
         begin
            next_state = S_IDLE;
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         state <= S_IDLE;
         err <= ERR_NONE;
         cur_off <= REG_RESET;
         acc_ns <= 32'h0000_0000;
         retry <= 4'h0;
         wdata <= 32'h0000_0000;
         armed_addr <= 24'h00_0000;
      end
      else
      begin
         state <= next_state;
         err <= next_err;
         cur_off <= next_off;
         acc_ns <= next_acc;
         retry <= next_retry;
         wdata <= next_wdata;
         if (state == S_IDLE && unlock_first)
         begin
            armed_addr <= trig_addr_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Software writes are dropped while an operation runs, so the
   // command words cannot change under the sequencer.
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < 5; i++)
         begin
            gpr[i] <= REG_RESET;
         end
         stack_free <= REG_RESET;
         flash_segment_select <= SEG_RESET;
      end
      else if (state == S_FINISH)
      begin
         gpr[0] <= {8'h00, err}; // RQ8 RQ23
         if (is_block)
         begin
            gpr[1] <= cur_off;
         end
         else if (is_stat && err == ERR_NONE)
         begin
            gpr[1] <= REVISION; // RQ16
         end
      end
      else if (sw_write)
      begin
         if (reg_addr_i <= REG_PERIOD)
         begin
            gpr[reg_addr_i[2:0]] <= reg_wdata_i; // RQ6
         end
         else if (reg_addr_i == REG_STACK)
         begin
            stack_free <= reg_wdata_i;
         end
         else if (reg_addr_i == REG_CTRL)
         begin
            flash_segment_select <= reg_wdata_i[CTRL_SEG_BIT];
         end
      end
   end

   wire [15:0] rd_mux =
      reg_addr_i <= REG_PERIOD ? gpr[reg_addr_i[2:0]] :
      reg_addr_i == REG_STACK ? stack_free :
      reg_addr_i == REG_CTRL ? {15'h0000, flash_segment_select} :
      reg_addr_i == REG_STAT ? {14'h0000, user_protection_bit_o, busy_o} :
      16'h0000;

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         reg_rdata_o <= 16'h0000;
         read_block_o <= 1'b0;
         array_prog_o <= 1'b0;
         array_erase_o <= 1'b0;
         array_addr_o <= 24'h00_0000;
         array_bank_o <= 2'h0;
         array_wdata_o <= 32'h0000_0000;
         array_wmask_o <= 2'h0;
         src_rd_o <= 1'b0;
         src_addr_o <= 16'h0000;
         busy_o <= 1'b0;
         user_protection_bit_o <= PROT_RESET;
      end
      else
      begin
         reg_rdata_o <= reg_re_i ? rd_mux : 16'h0000;
         read_block_o <= user_protection_bit_o && data_rd_i &&
            !fetch_from_flash_i && map_hit[2]; // RQ5
         array_prog_o <= next_state == S_PULSE && !is_erase;
         array_erase_o <= next_state == S_PULSE && is_erase; // RQ2
         array_addr_o <= {4'h0, seg, next_off};
         array_bank_o <= gpr[2][1:0]; // RQ2
         array_wdata_o <= next_wdata; // RQ1
         array_wmask_o <= is_double ? 2'h3 : 2'h1;
         src_rd_o <= next_state == S_FETCH;
         // Page base is added by the CPU bus, only the page offset leaves here
         src_addr_o <= gpr[3] + (next_off - gpr[1]); // RQ19
         busy_o <= !idle_like;
         if (state == S_CHECK && is_prot && check_err == ERR_NONE)
         begin
            user_protection_bit_o <= 1'b1; // RQ15
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);

   chk_unlock_pair: // RQ7
   assert property (state == S_ARMED && trig_we_i && !unlock_second && !sw_write
      |=> state == S_IDLE)
      else $error("unlock started without a matching second write");

   chk_start_cause: // RQ24
   assert property (state == S_CHECK |-> $past(state) == S_ARMED &&
      $past(trig_indirect_i) && $past(trig_addr_i) == armed_addr)
      else $error("operation started without an unlock pair");

   chk_result_reg: // RQ8
   assert property (state == S_FINISH |=> gpr[0] == {8'h00, $past(err)} && !busy_o)
      else $error("status code not left in register 0");

   chk_stack_guard: // RQ10
   assert property (state == S_CHECK && is_known && !is_stat && period_ok && !stack_ok
      |=> err == ERR_STACK ##1 !array_prog_o && !array_erase_o)
      else $error("low stack did not stop the operation");

   chk_bank_match: // RQ20
   assert property (state == S_CHECK && is_erase && period_ok && stack_ok &&
      gpr[1] == KEY_A && gpr[2] != gpr[3] |=> err == ERR_BANK && state == S_FINISH)
      else $error("erase went on with differing bank numbers");

   chk_bad_cmd: // RQ23
   assert property (state == S_CHECK && !is_known |=> err == ERR_BAD_CMD [*2])
      else $error("unknown command not reported as FFh");

   chk_odd_addr: // RQ17
   assert property (state == S_CHECK && is_single && period_ok && stack_ok &&
      gpr[1][0] |=> err == ERR_ADDR)
      else $error("odd target offset accepted");

   chk_block_span: // RQ18
   assert property (state == S_CHECK && is_block && period_ok && stack_ok && addr_ok &&
      gpr[2] < gpr[1] |=> err == ERR_COUNT)
      else $error("negative block span accepted");

   chk_read_block: // RQ5
   assert property (user_protection_bit_o && data_rd_i && fetch_from_flash_i
      |=> !read_block_o)
      else $error("flash-resident code was blocked");

   chk_pulse_len: // RQ21
   // Time summed from the period word must cover the pulse when it ends
   assert property ($fell(array_prog_o) |-> acc_ns >= PROG_NS)
      else $error("program pulse shorter than its timed length");

endmodule

// File: test/efcs_flash_model.sv
// Purpose: Behavioural flash array and source memory facing the sequencer
// Assumes: Verify answer is read one cycle after the pulse ends
// Notes:   fail_i makes every verify fail, to drive the retry path

`timescale 1ns/1ps

module efcs_flash_model
(
   input wire logic clock_i,
   input wire logic fail_i,
   input wire logic array_prog_i,
   input wire logic [23:0] array_addr_i,
   input wire logic [31:0] array_wdata_i,
   input wire logic src_rd_i,
   input wire logic [15:0] src_addr_i,
   output logic array_ok_o,
   output logic [15:0] src_data_o,
   output logic [23:0] last_addr_o,
   output logic [31:0] last_data_o
);
   // ----------------------------------
   // Array and source port
   // ----------------------------------
   assign array_ok_o = !fail_i;
   initial src_data_o = 16'h0000;
   always @(posedge clock_i)
   begin
      if (array_prog_i)
      begin
         last_addr_o <= array_addr_i;
         last_data_o <= array_wdata_i;
      end
      // A released source bus must not look like stale valid data
      src_data_o <= src_rd_i ? (src_addr_i ^ 16'h5A5A) : ~src_data_o;
   end
endmodule

// File: test/embedded_flash_command_sequencer_tb.sv
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Segment 0 mapping, trigger at an even flash address
// Notes:   Pulse lengths are shortened through the design parameters

`timescale 1ns/1ps

module embedded_flash_command_sequencer_tb;
   import efcs_pkg::*;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0, trig_gpr_i = 4'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_we_i = 1'b0, reg_re_i = 1'b0, trig_we_i = 1'b0, trig_indirect_i = 1'b0;
   logic data_rd_i = 1'b0, fetch_from_flash_i = 1'b0, flash_fail = 1'b0;
   logic [23:0] trig_addr_i = 24'h00_0000, data_rd_addr_i = 24'h00_0000;
   logic [15:0] reg_rdata_o, src_addr_o, src_data_i, v;
   logic read_block_o, array_prog_o, array_erase_o, src_rd_o, busy_o;
   logic user_protection_bit_o, array_ok_i;
   logic [23:0] array_addr_o, last_addr;
   logic [31:0] array_wdata_o, last_data;
   logic [1:0] array_bank_o, array_wmask_o;
   logic [1:0] seen_bank = 2'h0, seen_mask = 2'h0;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;

   efcs_sequencer #(.PROG_NS(32'h0000_0028), .ERASE_NS(32'h0000_0064)) dut
   (
      .clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
      .trig_we_i, .trig_addr_i, .trig_indirect_i, .trig_gpr_i, .data_rd_i,
      .data_rd_addr_i, .fetch_from_flash_i, .read_block_o, .array_prog_o, .array_erase_o,
      .array_addr_o, .array_bank_o, .array_wdata_o, .array_wmask_o, .array_ok_i,
      .src_rd_o, .src_addr_o, .src_data_i, .busy_o, .user_protection_bit_o
   );

   efcs_flash_model partner
   (
      .clock_i(clock_i), .fail_i(flash_fail), .array_prog_i(array_prog_o),
      .array_addr_i(array_addr_o), .array_wdata_i(array_wdata_o), .src_rd_i(src_rd_o),
      .src_addr_i(src_addr_o), .array_ok_o(array_ok_i), .src_data_o(src_data_i),
      .last_addr_o(last_addr), .last_data_o(last_data)
   );

   // Keep the bank of the last erase pulse and the mask of the last program pulse for later checks
   always @(posedge clock_i)
   begin
      if (array_erase_o)
         seen_bank <= array_bank_o;
      if (array_prog_o)
         seen_mask <= array_wmask_o;
   end

   // ----------------------------------
   // Clock, timeout and verdict
   // ----------------------------------
   initial
   begin
      forever #5 clock_i = ~clock_i;
   end

   task automatic wrap_up();
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up();
      end
   end

   // ----------------------------------
   // Bus and check tasks
   // ----------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clock_i);
      reg_re_i <= 1'b0;
      @(posedge clock_i);
      d = reg_rdata_o;
   endtask

   // Loads R0..R5, unlocks (optionally broken by a register write), checks R0
   task automatic op(input logic [15:0] c, r1, r2, r3, r4, r5, input logic gap,
      input logic [7:0] e);
      logic [15:0] val[6];
      int n;
      val = '{c, r1, r2, r3, r4, r5};
      n = 0;
      for (int i = 0; i < 6; i++)
         wr(i[3:0], val[i]);
      @(posedge clock_i);
      trig_we_i <= 1'b1;
      trig_addr_i <= 24'h00_1000;
      @(posedge clock_i);
      if (gap)
      begin
         trig_we_i <= 1'b0;
         wr(REG_ARG3, r3);
         trig_we_i <= 1'b1;
      end
      trig_indirect_i <= 1'b1;
      trig_gpr_i <= 4'h7;
      @(posedge clock_i);
      trig_we_i <= 1'b0;
      trig_indirect_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      while (busy_o !== 1'b0 && n < 1000)
      begin
         @(posedge clock_i);
         n++;
      end
      chk(n < 1000, 1'b1);
      rd(REG_CMD, v);
      chk(v, gap ? c : {8'h00, e});
   endtask

   task automatic rd_flash(input logic from_flash, input logic exp);
      @(posedge clock_i);
      data_rd_i <= 1'b1;
      data_rd_addr_i <= 24'h00_0100;
      fetch_from_flash_i <= from_flash;
      @(posedge clock_i);
      data_rd_i <= 1'b0;
      @(posedge clock_i);
      chk(read_block_o, exp);
   endtask

   // ----------------------------------
   // Scenarios
   // ----------------------------------
   initial
   begin
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      rd(REG_STAT, v);
      chk(v, 16'h0000);
      rd_flash(1'b0, 1'b0);
      op(16'h55A0, 16'h0100, 16'hBEEF, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_NONE);
      chk(last_addr, 24'h00_0100);
      chk(last_data[15:0], 16'hBEEF);
      chk(seen_mask, 2'h1);
      op(16'hDD40, 16'h0104, 16'h1111, 16'h2222, 16'h0032, 16'h0032, 1'b0, ERR_NONE);
      chk(last_data, 32'h2222_1111);
      chk(seen_mask, 2'h3);
      op(16'h55A0, 16'h0101, 16'h0001, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_ADDR);
      op(16'h55A5, 16'h0100, 16'h0001, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_ADDR);
      op(16'h1234, 16'h0100, 16'h0001, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_BAD_CMD);
      op(16'h55A0, 16'h0100, 16'h0001, 16'h0000, 16'h0014, 16'h0032, 1'b0, ERR_PERIOD);
      op(16'h55A0, 16'h0100, 16'h0001, 16'h0000, 16'h0032, 16'h0031, 1'b0, ERR_STACK);
      op(16'hEEEE, 16'h5555, 16'h0001, 16'h0002, 16'h0032, 16'h0032, 1'b0, ERR_BANK);
      op(16'hEEEE, 16'h1234, 16'h0002, 16'h0002, 16'h0032, 16'h0032, 1'b0, ERR_BAD_CMD);
      op(16'hEEEE, 16'h5555, 16'h0002, 16'h0002, 16'h0032, 16'h0032, 1'b0, ERR_NONE);
      chk(seen_bank, 2'h2);
      op(16'hAA50, 16'h0000, 16'h4000, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_COUNT);
      op(16'hAA50, 16'h0102, 16'h0100, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_COUNT);
      op(16'hAA50, 16'h0000, 16'h0010, 16'h3FF8, 16'h0032, 16'h0032, 1'b0, ERR_SOURCE);
      op(16'hAA50, 16'h0100, 16'h0102, 16'h0200, 16'h0032, 16'h0032, 1'b0, ERR_NONE);
      chk(last_data[15:0], 16'h5858);
      rd(REG_ARG1, v);
      chk(v, 16'h0102);
      op(16'h7777, 16'h0000, 16'h0000, 16'h0000, 16'h0032, 16'h0000, 1'b0, ERR_NONE);
      rd(REG_ARG1, v);
      chk(v, 16'h0100);
      flash_fail <= 1'b1;
      op(16'h55A0, 16'h0200, 16'h0001, 16'h0000, 16'h0032, 16'h0032, 1'b0, ERR_PROG);
      flash_fail <= 1'b0;
      op(16'h55A0, 16'h0200, 16'h00AA, 16'h0000, 16'h0032, 16'h0032, 1'b1, ERR_NONE);
      chk(last_data[15:0], 16'h0001);
      op(16'hCCCC, 16'h5555, 16'h3333, 16'hAAAA, 16'h0032, 16'h0032, 1'b0, ERR_NONE);
      rd(REG_STAT, v);
      chk(v, 16'h0002);
      rd_flash(1'b0, 1'b1);
      rd_flash(1'b1, 1'b0);
      wrap_up();
   end
endmodule
